/* sloi_params.svh */
`ifndef SLOI_PARAMS_SVH
`define SLOI_PARAMS_SVH
`define SLOI_OP_SIGN_SKIP    6'h1e
`define SLOI_OP_SIGN_SHIFT   6'h1f
`define SLOI_OP_SEL_SET      6'h20
`define SLOI_OP_SEL_CLEAR    6'h21
`define SLOI_OP_SEL_INVERT   6'h22
`define SLOI_OP_MASK_SUBST   6'h23
`define SLOI_OP_MASK_LOAD    6'h24
`define SLOI_OP_MASK_ADD     6'h25
`define SLOI_OP_MASK_SUB     6'h26
`define SLOI_OP_MASK_STORE   6'h27
`define SLOI_OP_IDX_ENTER    6'h28
`define SLOI_OP_IDX_INCREASE 6'h29
`define SLOI_OP_IDX_LOAD_UP  6'h2a
`define SLOI_OP_IDX_LOAD_LO  6'h2b
`define SLOI_OP_IDX_CMP_SKIP 6'h2c
`define SLOI_OP_IDX_CNT_JUMP 6'h2d
`define SLOI_OP_IDX_STORE_UP 6'h2e
`define SLOI_OP_IDX_STORE_LO 6'h2f
`define SLOI_OP_ADDR_SUB_UP  6'h30
`define SLOI_OP_ADDR_SUB_LO  6'h31
`define SLOI_OP_BLOCK_IN     6'h32
`define SLOI_WORD_W          48
`define SLOI_ADDR_W          15
`define SLOI_SIGN_BIT        47
`define SLOI_UPPER_ADDR_LSB  24
`define SLOI_FIFO_DEPTH      8
`endif

/* sloi_pkg.sv */
`default_nettype none
package sloi_pkg;
   typedef enum logic [1:0] {EX_SEQ, EX_FULL, EX_HALF, EX_JUMP} sloi_exit_t;
   typedef enum {ST_IDLE, ST_RD, ST_WR, ST_XIN} sloi_state_t;
   typedef struct packed {
      logic [5:0]  op;
      logic [2:0]  b;
      logic [14:0] m;
   } sloi_instr_t;
   typedef struct packed {
      logic        req;
      logic        we;
      logic [14:0] addr;
      logic [47:0] wdata;
   } sloi_mreq_t;
endpackage
`default_nettype wire

/* sloi_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sloi_params.svh"

module sloi_fifo #(
   parameter int W = 48,
   parameter int D = 8
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_r [D];
   logic [AW:0]  wp_r;
   logic [AW:0]  rp_r;

   // Depth must be a power of two for the wrap bit to work
   assign in_ready_o  = !((wp_r[AW] != rp_r[AW]) &&
                          (wp_r[AW-1:0] == rp_r[AW-1:0]));
   assign out_valid_o = (wp_r != rp_r);
   assign out_data_o  = mem_r[rp_r[AW-1:0]];

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         wp_r <= '0;
      else if (in_valid_i && in_ready_o)
      begin
         mem_r[wp_r[AW-1:0]] <= in_data_i;
         wp_r <= wp_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         rp_r <= '0;
      else if (out_valid_o && out_ready_i)
         rp_r <= rp_r + 1'b1;
   end
endmodule

module sloi_top
   import sloi_pkg::*;
(
   input  wire logic        MCLK_I,
   input  wire logic        NRST_I,
   input  wire logic        START_I,
   input  wire sloi_instr_t INSTR_I,
   input  wire logic [47:0] ACC_I,
   input  wire logic [47:0] MASK_I,
   input  wire logic        OVF_SEL_I,
   input  wire logic        OVF_CLR_I,
   output var sloi_mreq_t   MEM_O,
   input  wire logic        MEM_ACK_I,
   input  wire logic [47:0] MEM_RDATA_I,
   input  wire logic        EXT_VALID_I,
   input  wire logic [47:0] EXT_DATA_I,
   output logic             EXT_ACK_O,
   output logic             DONE_O,
   output var sloi_exit_t   EXIT_O,
   output logic             ACC_WE_O,
   output logic [47:0]      ACC_O,
   output logic             OVF_O,
   output logic             OVF_IRQ_O,
   output logic             BUSY_O
);
   sloi_state_t st_r;
   sloi_instr_t ir_r;
   sloi_instr_t cur;
   logic [14:0] idx_r [8];
   logic [14:0] bval;
   logic [14:0] ea;
   logic [14:0] xaddr;
   logic [14:0] in_left_r;
   logic [47:0] rd;
   logic [47:0] masked;
   logic [47:0] sum;
   logic        is_sub;
   logic        ovf_c;
   logic        ovf_set;
   logic        start;
   logic        rd_ack;
   logic        b_ok;
   logic        busy_r;
   logic        xv_meta_r;
   logic        xv_s_r;
   logic [47:0] xd_meta_r;
   logic [47:0] xd_s_r;
   logic        take;
   logic        f_in_rdy;
   logic        f_out_v;
   logic        f_out_rdy;
   logic [47:0] f_out_d;

   function automatic logic [47:0] oc_add48(input logic [47:0] x,
                                            input logic [47:0] y);
      logic [48:0] s;
      s = {1'b0, x} + {1'b0, y};
      return s[47:0] + {47'h0, s[48]};
   endfunction

   function automatic logic [14:0] oc_add15(input logic [14:0] x,
                                            input logic [14:0] y);
      logic [15:0] s;
      s = {1'b0, x} + {1'b0, y};
      return s[14:0] + {14'h0, s[15]};
   endfunction

   assign start  = START_I && (st_r == ST_IDLE);
   assign rd_ack = (st_r == ST_RD) && MEM_ACK_I;
   assign cur    = (st_r == ST_IDLE) ? INSTR_I : ir_r;
   // Entries 0 and 7 are never written, so they read as zero
   assign bval   = idx_r[cur.b];
   assign b_ok   = (cur.b != 3'h0) && (cur.b != 3'h7);
   assign ea     = cur.m + bval;
   assign xaddr  = ir_r.m + bval - 15'h1;
   assign rd     = MEM_RDATA_I;
   assign masked = rd & MASK_I;
   assign is_sub = (ir_r.op == `SLOI_OP_MASK_SUB);
   assign sum    = oc_add48(ACC_I, is_sub ? ~masked : masked);
   assign ovf_c  = (ACC_I[47] == (is_sub ? ~masked[47] : masked[47])) &&
                   (sum[47] != ACC_I[47]);
   assign ovf_set = rd_ack && ovf_c &&
                    (ir_r.op == `SLOI_OP_MASK_ADD || is_sub);
   assign BUSY_O  = busy_r;

   always_ff @(posedge MCLK_I)
   begin
      if (!NRST_I)
      begin
         st_r     <= ST_IDLE;
         ir_r     <= '0;
         MEM_O    <= '0;
         DONE_O   <= 1'b0;
         EXIT_O   <= EX_SEQ;
         ACC_WE_O <= 1'b0;
         ACC_O    <= '0;
         busy_r   <= 1'b0;
         for (int i = 0; i < 8; i++)
            idx_r[i] <= '0;
      end
      else
      begin
         DONE_O   <= 1'b0;
         ACC_WE_O <= 1'b0;
         case (st_r)
            ST_IDLE:
               if (start)
               begin
                  ir_r       <= INSTR_I;
                  MEM_O.addr <= ea;
                  MEM_O.we   <= 1'b0;
                  busy_r     <= 1'b1;
                  EXIT_O     <= EX_SEQ;
                  st_r       <= ST_RD;
                  MEM_O.req  <= 1'b1;
                  case (INSTR_I.op)
                     `SLOI_OP_IDX_LOAD_UP, `SLOI_OP_IDX_LOAD_LO,
                     `SLOI_OP_IDX_STORE_UP, `SLOI_OP_IDX_STORE_LO:
                        MEM_O.addr <= INSTR_I.m;
                     `SLOI_OP_MASK_STORE:
                     begin
                        MEM_O.we    <= 1'b1;
                        MEM_O.wdata <= ACC_I & MASK_I;
                        st_r        <= ST_WR;
                     end
                     `SLOI_OP_BLOCK_IN:
                     begin
                        MEM_O.req <= 1'b0;
                        st_r      <= (bval == 15'h0) ? ST_IDLE : ST_XIN;
                        DONE_O    <= (bval == 15'h0);
                        busy_r    <= (bval != 15'h0);
                     end
                     `SLOI_OP_IDX_ENTER, `SLOI_OP_IDX_INCREASE,
                     `SLOI_OP_IDX_CMP_SKIP, `SLOI_OP_IDX_CNT_JUMP:
                     begin
                        MEM_O.req <= 1'b0;
                        st_r      <= ST_IDLE;
                        busy_r    <= 1'b0;
                        DONE_O    <= 1'b1;
                        case (INSTR_I.op)
                           `SLOI_OP_IDX_ENTER:
                              if (b_ok)
                                 idx_r[INSTR_I.b] <= INSTR_I.m;
                           `SLOI_OP_IDX_INCREASE:
                              if (b_ok)
                                 idx_r[INSTR_I.b] <= oc_add15(bval, INSTR_I.m);
                           `SLOI_OP_IDX_CMP_SKIP:
                           begin
                              EXIT_O <= (bval == INSTR_I.m) ? EX_FULL
                                                            : EX_HALF;
                              if (b_ok)
                                 idx_r[INSTR_I.b] <= (bval == INSTR_I.m) ?
                                    15'h0 : oc_add15(bval, 15'h1);
                           end
                           default:
                              if (bval != 15'h0)
                              begin
                                 EXIT_O <= EX_JUMP;
                                 // Nonzero, so a plain decrement reaches +0
                                 idx_r[INSTR_I.b] <= bval - 15'h1;
                              end
                        endcase
                     end
                     default: ;
                  endcase
               end
            ST_RD:
               if (MEM_ACK_I)
               begin
                  // Read-modify-write ops reuse the held address
                  MEM_O.req <= 1'b0;
                  st_r      <= ST_IDLE;
                  busy_r    <= 1'b0;
                  DONE_O    <= 1'b1;
                  ACC_WE_O  <= 1'b1;
                  ACC_O     <= ACC_I;
                  case (ir_r.op)
                     `SLOI_OP_SEL_SET:    ACC_O <= ACC_I | rd;
                     `SLOI_OP_SEL_CLEAR:  ACC_O <= ACC_I & ~rd;
                     `SLOI_OP_SEL_INVERT: ACC_O <= ACC_I ^ rd;
                     `SLOI_OP_MASK_SUBST:
                        ACC_O <= (ACC_I & ~MASK_I) | masked;
                     `SLOI_OP_MASK_LOAD:  ACC_O <= masked;
                     `SLOI_OP_MASK_ADD, `SLOI_OP_MASK_SUB: ACC_O <= sum;
                     default:
                     begin
                        ACC_WE_O <= 1'b0;
                        DONE_O   <= 1'b0;
                        st_r     <= ST_WR;
                        busy_r   <= 1'b1;
                        MEM_O.req <= 1'b1;
                        MEM_O.we  <= 1'b1;
                        case (ir_r.op)
                           `SLOI_OP_SIGN_SKIP:
                           begin
                              EXIT_O    <= rd[`SLOI_SIGN_BIT] ? EX_FULL
                                                              : EX_HALF;
                              MEM_O.req <= 1'b0;
                              st_r      <= ST_IDLE;
                              busy_r    <= 1'b0;
                              DONE_O    <= 1'b1;
                           end
                           `SLOI_OP_SIGN_SHIFT:
                           begin
                              EXIT_O <= rd[`SLOI_SIGN_BIT] ? EX_FULL
                                                           : EX_HALF;
                              MEM_O.wdata <= {rd[46:0], rd[47]};
                           end
                           `SLOI_OP_IDX_LOAD_UP, `SLOI_OP_IDX_LOAD_LO:
                           begin
                              MEM_O.req <= 1'b0;
                              st_r      <= ST_IDLE;
                              busy_r    <= 1'b0;
                              DONE_O    <= 1'b1;
                              if (b_ok)
                                 idx_r[ir_r.b] <=
                                    (ir_r.op == `SLOI_OP_IDX_LOAD_UP) ?
                                    rd[38:24] : rd[14:0];
                           end
                           `SLOI_OP_IDX_STORE_UP:
                              MEM_O.wdata <= {rd[47:39], bval, rd[23:0]};
                           `SLOI_OP_IDX_STORE_LO:
                              MEM_O.wdata <= {rd[47:15], bval};
                           `SLOI_OP_ADDR_SUB_UP:
                              MEM_O.wdata <= {rd[47:39], ACC_I[14:0],
                                              rd[23:0]};
                           default:
                              MEM_O.wdata <= {rd[47:15], ACC_I[14:0]};
                        endcase
                     end
                  endcase
               end
            ST_WR:
               if (MEM_ACK_I)
               begin
                  MEM_O.req <= 1'b0;
                  st_r      <= ST_IDLE;
                  busy_r    <= 1'b0;
                  DONE_O    <= 1'b1;
               end
            default:
               if (MEM_O.req && MEM_ACK_I)
               begin
                  MEM_O.req <= 1'b0;
                  // Count is nonzero here; 1 must land on +0, not -0
                  idx_r[ir_r.b] <= bval - 15'h1;
                  if (bval == 15'h1)
                  begin
                     st_r   <= ST_IDLE;
                     busy_r <= 1'b0;
                     DONE_O <= 1'b1;
                  end
               end
               else if (!MEM_O.req && f_out_v)
               begin
                  MEM_O.req   <= 1'b1;
                  MEM_O.we    <= 1'b1;
                  MEM_O.addr  <= xaddr;
                  MEM_O.wdata <= f_out_d;
               end
         endcase
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!NRST_I)
      begin
         OVF_O     <= 1'b0;
         OVF_IRQ_O <= 1'b0;
      end
      else
      begin
         // A new overflow beats a clear in the same cycle
         OVF_O     <= ovf_set || (OVF_O && !OVF_CLR_I);
         OVF_IRQ_O <= ovf_set && OVF_SEL_I;
      end
   end

   always_ff @(posedge MCLK_I)
   begin
      if (!NRST_I)
      begin
         xv_meta_r <= 1'b0;
         xv_s_r    <= 1'b0;
         xd_meta_r <= '0;
         xd_s_r    <= '0;
      end
      else
      begin
         xv_meta_r <= EXT_VALID_I;
         xv_s_r    <= xv_meta_r;
         xd_meta_r <= EXT_DATA_I;
         xd_s_r    <= xd_meta_r;
      end
   end

   // Data passes the same two flops as valid, so both are seen in the same cycle
   assign take = xv_s_r && !EXT_ACK_O && f_in_rdy && (st_r == ST_XIN) &&
                 (in_left_r != 15'h0);

   always_ff @(posedge MCLK_I)
   begin
      if (!NRST_I)
      begin
         EXT_ACK_O <= 1'b0;
         in_left_r <= '0;
      end
      else
      begin
         if (start && INSTR_I.op == `SLOI_OP_BLOCK_IN)
            in_left_r <= bval;
         else if (take)
            in_left_r <= in_left_r - 15'h1;
         if (take)
            EXT_ACK_O <= 1'b1;
         else if (!xv_s_r)
            EXT_ACK_O <= 1'b0;
      end
   end

   assign f_out_rdy = (st_r == ST_XIN) && !MEM_O.req;

   sloi_fifo #(.W(`SLOI_WORD_W), .D(`SLOI_FIFO_DEPTH)) u_fifo (
      .clk_i       (MCLK_I),
      .rst_n_i     (NRST_I),
      .in_valid_i  (take),
      .in_data_i   (xd_s_r),
      .in_ready_o  (f_in_rdy),
      .out_valid_o (f_out_v),
      .out_data_o  (f_out_d),
      .out_ready_i (f_out_rdy)
   );

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (!NRST_I);

   property p_sign_skip;
      rd_ack && ir_r.op == `SLOI_OP_SIGN_SKIP |=> DONE_O &&
         EXIT_O == ($past(rd[47]) ? EX_FULL : EX_HALF);
   endproperty
   a_sign_skip: assert property (p_sign_skip) else $error("skip exit");
   property p_sign_shift;
      rd_ack && ir_r.op == `SLOI_OP_SIGN_SHIFT |=> MEM_O.req && MEM_O.we &&
         MEM_O.wdata == {$past(rd[46:0]), $past(rd[47])} && !DONE_O;
   endproperty
   a_sign_shift: assert property (p_sign_shift) else $error("rotate");
   property p_sel_set;
      rd_ack && ir_r.op == `SLOI_OP_SEL_SET |=>
         ACC_WE_O && ACC_O == ($past(ACC_I) | $past(rd));
   endproperty
   a_sel_set: assert property (p_sel_set) else $error("set");
   property p_subst;
      rd_ack && ir_r.op == `SLOI_OP_MASK_SUBST |=> ACC_O ==
         (($past(ACC_I) & ~$past(MASK_I)) | ($past(rd) & $past(MASK_I)));
   endproperty
   a_subst: assert property (p_subst) else $error("substitute");
   property p_ovf;
      ovf_set |=> OVF_O && OVF_IRQ_O == $past(OVF_SEL_I);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow");
   property p_mstore;
      start && INSTR_I.op == `SLOI_OP_MASK_STORE |=> MEM_O.req &&
         MEM_O.we && MEM_O.wdata == $past(ACC_I & MASK_I);
   endproperty
   a_mstore: assert property (p_mstore) else $error("store");
   property p_enter;
      start && INSTR_I.op == `SLOI_OP_IDX_ENTER && b_ok |=>
         idx_r[$past(INSTR_I.b)] == $past(INSTR_I.m) && DONE_O;
   endproperty
   a_enter: assert property (p_enter) else $error("enter");
   property p_cnt_jump;
      start && INSTR_I.op == `SLOI_OP_IDX_CNT_JUMP |=>
         EXIT_O == ($past(bval) != 15'h0 ? EX_JUMP : EX_SEQ);
   endproperty
   a_cnt_jump: assert property (p_cnt_jump) else $error("jump");
   property p_xfer;
      st_r == ST_XIN && MEM_O.req && MEM_ACK_I |=>
         idx_r[ir_r.b] == $past(bval) - 15'h1;
   endproperty
   a_xfer: assert property (p_xfer) else $error("count");

   c_xfer_end: cover property (st_r == ST_XIN ##1 st_r == ST_IDLE && DONE_O);
   c_ovf:      cover property (ovf_set ##1 OVF_IRQ_O);
   c_half:     cover property (DONE_O && EXIT_O == EX_HALF);
   c_full:     cover property (f_out_v && !f_in_rdy);
endmodule
`default_nettype wire

/* sloi_ext_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sloi_ext_model
   import sloi_pkg::*;
(
   input  wire logic        clk_i,
   input  wire sloi_mreq_t  mreq_i,
   output logic             ack_o,
   output logic [47:0]      rdata_o,
   output logic             ext_valid_o,
   output logic [47:0]      ext_data_o,
   input  wire logic        ext_ack_i
);
   logic [47:0] mem [0:32767];
   logic [47:0] xq [$];
   int          delay    = 0;
   int          wait_cnt = 0;

   initial
   begin
      ack_o       = 1'h0;
      rdata_o     = 48'h0;
      ext_valid_o = 1'h0;
      ext_data_o  = 48'h0;
   end

   // Read data toggles outside the ack cycle so a late sample never matches
   always @(posedge clk_i)
   begin
      ack_o   <= 1'h0;
      rdata_o <= ~rdata_o;
      if (mreq_i.req && !ack_o && wait_cnt < delay)
         wait_cnt <= wait_cnt + 1;
      else if (mreq_i.req && !ack_o)
      begin
         ack_o    <= 1'h1;
         wait_cnt <= 0;
         if (mreq_i.we)
            mem[mreq_i.addr] <= mreq_i.wdata;
         else
            rdata_o <= mem[mreq_i.addr];
      end
   end

   // Four-phase: next word only once the acknowledge has dropped
   always @(posedge clk_i)
      if (!ext_valid_o && !ext_ack_i && xq.size() > 0)
      begin
         ext_valid_o <= 1'h1;
         ext_data_o  <= xq.pop_front();
      end
      else if (ext_valid_o && ext_ack_i)
      begin
         ext_valid_o <= 1'h0;
         ext_data_o  <= ~ext_data_o;
      end
endmodule
`default_nettype wire

/* sloi_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sloi_top_tb
   import sloi_pkg::*;
;
   typedef struct {
      logic [5:0]  op;
      logic [47:0] a;
      logic [47:0] q;
      logic [47:0] mv;
      logic [47:0] exp;
      logic        we;
      sloi_exit_t  ex;
      logic        tm;
   } sloi_row_t;
   localparam logic [47:0] AV = 48'h0f0f_0f0f_0f0f;
   localparam logic [47:0] QV = 48'hffff_0000_ffff;
   localparam logic [47:0] MV = 48'h00ff_00ff_00ff;
   localparam logic [47:0] F  = 48'hffff_ffff_ffff;
   localparam logic [47:0] N  = 48'h8000_0000_0000;
   logic        clk     = 1'h0;
   logic        nrst    = 1'h0;
   logic        start   = 1'h0;
   sloi_instr_t instr   = '0;
   logic [47:0] acc     = '0;
   logic [47:0] mask    = '0;
   logic        ovf_sel = 1'h1;
   logic        ovf_clr = 1'h0;
   sloi_mreq_t  mreq;
   logic        mack;
   logic [47:0] rdata;
   logic        xvalid;
   logic [47:0] xdata;
   logic        xack;
   logic        done;
   sloi_exit_t  ex;
   logic        acc_we;
   logic [47:0] acc_o;
   logic        ovf;
   logic        irq;
   logic        busy;
   logic        got_we;
   logic        got_irq;
   int          num_errors = 0;
   int          checks     = 0;
   sloi_row_t   rows [14];

   always #2.5 clk = ~clk;

   sloi_top sloi_top_i (
      .MCLK_I(clk), .NRST_I(nrst), .START_I(start), .INSTR_I(instr),
      .ACC_I(acc), .MASK_I(mask), .OVF_SEL_I(ovf_sel), .OVF_CLR_I(ovf_clr),
      .MEM_O(mreq), .MEM_ACK_I(mack), .MEM_RDATA_I(rdata),
      .EXT_VALID_I(xvalid), .EXT_DATA_I(xdata), .EXT_ACK_O(xack),
      .DONE_O(done), .EXIT_O(ex), .ACC_WE_O(acc_we), .ACC_O(acc_o),
      .OVF_O(ovf), .OVF_IRQ_O(irq), .BUSY_O(busy)
   );

   sloi_ext_model sloi_ext_model_i (
      .clk_i(clk), .mreq_i(mreq), .ack_o(mack), .rdata_o(rdata),
      .ext_valid_o(xvalid), .ext_data_o(xdata), .ext_ack_i(xack)
   );

   function automatic logic [47:0] mr(input logic [14:0] a);
      return sloi_ext_model_i.mem[a];
   endfunction

   task automatic end_of_test();
      if (num_errors == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chx(input sloi_exit_t e);
      chk({46'h0, ex}, {46'h0, e});
   endtask

   // Pulses are collected at every falling edge up to and including DONE
   task automatic run(input logic [5:0] op, input logic [2:0] b,
                      input logic [14:0] m);
      int n;
      @(negedge clk);
      start = 1'h1;
      instr = {op, b, m};
      @(negedge clk);
      start = 1'h0;
      n = 0;
      got_we = 1'h0;
      got_irq = 1'h0;
      while (done !== 1'h1 && n < 2000)
      begin
         got_we |= acc_we;
         got_irq |= irq;
         @(negedge clk);
         n++;
      end
      got_we |= acc_we;
      got_irq |= irq;
      if (n >= 2000)
      begin
         num_errors++;
         end_of_test();
      end
   endtask

   initial
   begin
      rows = '{
         '{6'h1e, AV, QV, N, N, 1'h0, EX_FULL, 1'h1},
         '{6'h1e, AV, QV, MV, MV, 1'h0, EX_HALF, 1'h1},
         '{6'h1f, AV, QV, N + 48'h1, 48'h3, 1'h0, EX_FULL, 1'h1},
         '{6'h1f, AV, QV, N >> 1, N, 1'h0, EX_HALF, 1'h1},
         '{6'h20, AV, QV, MV, 48'h0fff_0fff_0fff, 1'h1, EX_SEQ, 1'h0},
         '{6'h21, AV, QV, MV, 48'h0f00_0f00_0f00, 1'h1, EX_SEQ, 1'h0},
         '{6'h22, AV, QV, MV, 48'h0ff0_0ff0_0ff0, 1'h1, EX_SEQ, 1'h0},
         '{6'h23, AV, QV, MV, 48'h00ff_0f0f_00ff, 1'h1, EX_SEQ, 1'h0},
         '{6'h24, AV, QV, MV, 48'h00ff_0000_00ff, 1'h1, EX_SEQ, 1'h0},
         '{6'h25, AV, QV, MV, 48'h100e_0f0f_100e, 1'h1, EX_SEQ, 1'h0},
         '{6'h26, AV, QV, MV, 48'h0e10_0f0f_0e10, 1'h1, EX_SEQ, 1'h0},
         '{6'h27, AV, QV, MV, 48'h0f0f_0000_0f0f, 1'h0, EX_SEQ, 1'h1},
         '{6'h30, AV, QV, F, 48'hff8f_0fff_ffff, 1'h0, EX_SEQ, 1'h1},
         '{6'h31, AV, QV, F, 48'hffff_ffff_8f0f, 1'h0, EX_SEQ, 1'h1}
      };
      repeat (4) @(negedge clk);
      nrst = 1'h1;
      chk({42'h0, done, busy, ovf, irq, mreq.req, xack}, 48'h0);
      foreach (rows[i])
      begin
         sloi_ext_model_i.delay = i % 3;
         sloi_ext_model_i.mem[15'h10 + 15'(i)] = rows[i].mv;
         acc = rows[i].a;
         mask = rows[i].q;
         run(rows[i].op, 3'h0, 15'h10 + 15'(i));
         chx(rows[i].ex);
         chk({46'h0, got_we, got_irq}, {46'h0, rows[i].we, 1'h0});
         if (rows[i].we)
            chk(acc_o, rows[i].exp);
         if (rows[i].tm)
            chk(mr(15'h10 + 15'(i)), rows[i].exp);
      end
      acc = 48'h7fff_ffff_ffff;
      mask = F;
      sloi_ext_model_i.mem[15'h40] = 48'h1;
      run(6'h25, 3'h0, 15'h40);
      chk({46'h0, ovf, got_irq}, 48'h3);
      ovf_clr = 1'h1;
      @(negedge clk);
      ovf_clr = 1'h0;
      @(negedge clk);
      chk({47'h0, ovf}, 48'h0);
      acc = N;
      ovf_sel = 1'h0;
      run(6'h26, 3'h0, 15'h40);
      chk({46'h0, ovf, got_irq}, 48'h2);
      acc = '0;
      sloi_ext_model_i.mem[15'h200] = 48'h2;
      sloi_ext_model_i.mem[15'h205] = 48'h1;
      run(6'h28, 3'h1, 15'h5);
      run(6'h20, 3'h1, 15'h200);
      chk(acc_o, 48'h1);
      run(6'h28, 3'h0, 15'h5);
      run(6'h20, 3'h0, 15'h200);
      chk(acc_o, 48'h2);
      run(6'h29, 3'h1, 15'h7ffe);
      run(6'h2c, 3'h1, 15'h4);
      chx(EX_FULL);
      run(6'h2c, 3'h1, 15'h3);
      chx(EX_HALF);
      run(6'h2d, 3'h1, 15'h0);
      chx(EX_JUMP);
      run(6'h2d, 3'h1, 15'h0);
      chx(EX_SEQ);
      sloi_ext_model_i.mem[15'h300] = 48'h0000_0200_0003;
      sloi_ext_model_i.mem[15'h310] = F;
      run(6'h2a, 3'h2, 15'h300);
      run(6'h2b, 3'h3, 15'h300);
      run(6'h2e, 3'h2, 15'h310);
      run(6'h2f, 3'h3, 15'h310);
      chk(mr(15'h310), 48'hff80_02ff_8003);
      // Slow memory lets the equipment outrun it, so the FIFO backs up to 7 of its 8 entries
      run(6'h28, 3'h4, 15'ha);
      sloi_ext_model_i.delay = 30;
      for (int k = 0; k < 11; k++)
         sloi_ext_model_i.xq.push_back(N + 48'(k));
      run(6'h32, 3'h4, 15'h600);
      chx(EX_SEQ);
      for (int k = 0; k < 10; k++)
         chk(mr(15'h609 - 15'(k)), N + 48'(k));
      repeat (10) @(negedge clk);
      chk({46'h0, xvalid, xack}, 48'h2);
      run(6'h32, 3'h4, 15'h600);
      chx(EX_SEQ);
      chk(mr(15'h600), N + 48'h9);
      // Reset in the middle of a read abandons it and clears the indexes
      @(negedge clk);
      start = 1'h1;
      instr = {6'h20, 3'h0, 15'h40};
      @(negedge clk);
      start = 1'h0;
      repeat (3) @(negedge clk);
      nrst = 1'h0;
      repeat (2) @(negedge clk);
      nrst = 1'h1;
      @(negedge clk);
      chk({42'h0, done, busy, ovf, irq, mreq.req, xack}, 48'h0);
      chk(acc_o, 48'h0);
      run(6'h2d, 3'h2, 15'h0);
      chx(EX_SEQ);
      end_of_test();
   end
endmodule
`default_nettype wire
